// File: design/rftx_consts.svh
// register map, field and timing constants of the tx framer
`ifndef RFTX_CONSTS_SVH
`define RFTX_CONSTS_SVH
// register indices; byte address is four times the index
`define RFTX_IDX_LAST_BYTE   10'h02e
`define RFTX_IDX_BURST_LEN   10'h030
`define RFTX_IDX_WAIT_CTRL   10'h031
`define RFTX_IDX_WAIT_LOW    10'h032
`define RFTX_IDX_FRAME_CTRL  10'h033
`define RFTX_IDX_TX_CONTROL  10'h038
`define RFTX_IDX_TX_STATUS   10'h039
// reset values
`define RFTX_RST_WAIT_CTRL   8'hc0
`define RFTX_RST_ZERO        8'h00
// field positions
`define RFTX_GRID_BIT        4
`define RFTX_SEND_BIT        3
`define RFTX_GAPSTART_BIT    7
`define RFTX_GAPUNIT_BIT     6
`define RFTX_TXPAR_BIT       7
`define RFTX_RXPAR_BIT       6
`define RFTX_GO_BIT          0
`define RFTX_BURSTEN_BIT     1
`define RFTX_BURSTLVL_BIT    2
`define RFTX_BUSY_BIT        0
`define RFTX_GAPRUN_BIT      1
`define RFTX_PARERR_BIT      2
// one wait unit in carrier mode is 16 carrier cycles
`define RFTX_CARRIER_KHZ     13560
`define RFTX_CARRIER_PER_UNIT 16
`define RFTX_PCLK_KHZ        200000
`define RFTX_CARRIER_UNIT_CYC ((`RFTX_CARRIER_PER_UNIT * `RFTX_PCLK_KHZ) / `RFTX_CARRIER_KHZ)
`endif

// File: design/rftx_pkg.sv
// types shared by the tx framer modules
`default_nettype none
package rftx_pkg;
  typedef enum logic [8:0] {
    RFTX_IDLE  = 9'b0_0000_0001,
    RFTX_GAP   = 9'b0_0000_0010,
    RFTX_ALIGN = 9'b0_0000_0100,
    RFTX_SSYM  = 9'b0_0000_1000,
    RFTX_BURST = 9'b0_0001_0000,
    RFTX_DATA  = 9'b0_0010_0000,
    RFTX_PAR   = 9'b0_0100_0000,
    RFTX_ESYM  = 9'b0_1000_0000,
    RFTX_GUARD = 9'b1_0000_0000
  } rftx_state_t;
  typedef enum logic [2:0] {
    RFTX_K_DATA   = 3'h0,
    RFTX_K_PARITY = 3'h1,
    RFTX_K_SYMBOL = 3'h2,
    RFTX_K_BURST  = 3'h3,
    RFTX_K_STOP   = 3'h4
  } rftx_kind_t;
endpackage
`default_nettype wire

// File: design/rftx_gap_if.sv
// link between the framer and its inter-frame gap timer
`default_nettype none
interface rftx_gap_if;
  logic        arm;
  logic [10:0] count;
  logic        unit_sel;
  logic        busy;
  modport ctrl  (output arm, output count, output unit_sel, input busy);
  modport timer (input arm, input count, input unit_sel, output busy);
endinterface
`default_nettype wire

// File: design/rftx_gap_timer.sv
// inter-frame gap timer counting carrier or half-bit units
`default_nettype none
`include "rftx_consts.svh"
module rftx_gap_timer #(
  parameter int ETU_CYCLES = 64
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  rftx_gap_if.timer  gap
);
  localparam int HALF_CYC = (ETU_CYCLES / 2 < 1) ? 1 : ETU_CYCLES / 2;
  localparam int CAR_CYC  = `RFTX_CARRIER_UNIT_CYC;
  logic [10:0] left_ff;
  logic [10:0] nxt_left;
  logic [15:0] pre_ff;
  logic [15:0] nxt_pre;
  logic [15:0] unit_end;

  // one unit is a half bit period or sixteen carrier cycles
  always_comb begin
    unit_end = gap.unit_sel ? 16'(HALF_CYC - 1) : 16'(CAR_CYC - 1);
    nxt_left = left_ff;
    nxt_pre  = pre_ff;
    if (gap.arm) begin  // re-arm restarts the whole wait
      nxt_left = gap.count;
      nxt_pre  = 16'h0000;
    end else if (left_ff != 11'h000) begin
      if (pre_ff >= unit_end) begin
        nxt_pre  = 16'h0000;
        nxt_left = left_ff - 11'h001;
      end else begin
        nxt_pre = pre_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 11'h000;
      pre_ff  <= 16'h0000;
    end else begin
      left_ff <= nxt_left;
      pre_ff  <= nxt_pre;
    end
  end

  assign gap.busy = (left_ff != 11'h000);
endmodule // rftx_gap_timer
`default_nettype wire

// File: design/rftx_framer.sv
// transmit framing and timing block with its apb register file
// Behaviour
// - grid set: starts spaced whole ETUs apart
// - send-bytes cleared: symbols, burst and stops only, no data
// - last byte sends low N bits, 0=8
// - burst code maps to 8..256 bits
// - gap starts at tx or rx end
// - gap unit: 16 carrier cycles or half bit
// - gap count is 11 bits, upper three
// - no start before gap time has elapsed
// - stop length: none, stop, stop plus guards
// - tx parity bit appended after each byte
// - rx parity checked and stripped from bytes
// - trailing symbol select: none, 0, 1, 2
// - leading symbol select: none, 0, 1, 2
// - burst sent at selected level, configured length
// - wait control resets to c0
//
// The APB interface to the registers was decided locally.
`default_nettype none
`include "rftx_consts.svh"
module rftx_framer #(
  parameter int ETU_CYCLES = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_byte_valid,
  input  wire logic        tx_byte_last,
  output logic             tx_byte_ready,
  output logic             tx_strobe,
  output logic [2:0]       tx_kind,
  output logic             tx_bit,
  output logic [1:0]       tx_symbol,
  input  wire logic        rx_frame_end,
  input  wire logic [8:0]  rx_in_data,
  input  wire logic        rx_in_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_byte_valid,
  output logic             rx_parity_err
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam int EW = $clog2(ETU_CYCLES + 1);
  localparam logic [EW-1:0] ETU_LAST = EW'(ETU_CYCLES - 1);

  logic [7:0] lastb_ff, burst_ff, wctl_ff, wlo_ff, frame_ff, ctl_ff;
  logic [7:0] nxt_lastb, nxt_burst, nxt_wctl, nxt_wlo, nxt_frame, nxt_ctl;
  logic       parerr_ff, nxt_parerr, go_ff, nxt_go;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  rftx_pkg::rftx_state_t st_ff, nxt_st;
  logic [EW-1:0] etu_ff, nxt_etu, grid_ff, nxt_grid;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic [7:0]  sh_ff, nxt_sh;
  logic        last_ff, nxt_last, par_ff, nxt_par;
  logic        strobe_ff, nxt_strobe, bit_ff, nxt_bit, rdy_ff, nxt_rdy;
  logic [2:0]  kind_ff, nxt_kind;
  logic [1:0]  sym_ff, nxt_sym;
  logic [7:0]  rxb_ff, nxt_rxb;
  logic        rxv_ff, nxt_rxv, rxe_ff, nxt_rxe;
  logic        tick, tx_end, wr_en, rd_en, hit;
  logic [31:0] rd_word;
  rftx_pkg::rftx_state_t after_ssym, after_burst, after_data, after_esym;

  rftx_gap_if gap ();

  rftx_gap_timer #(.ETU_CYCLES(ETU_CYCLES)) u_gap (
    .pclk    (pclk),
    .presetn (presetn),
    .gap     (gap.timer)
  );

  // burst length code to number of burst bits
  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    case (code)
      3'h0:    burst_bits = 9'h008;
      3'h1:    burst_bits = 9'h010;
      3'h2:    burst_bits = 9'h020;
      3'h3:    burst_bits = 9'h030;
      3'h4:    burst_bits = 9'h040;
      3'h5:    burst_bits = 9'h060;
      3'h6:    burst_bits = 9'h080;
      default: burst_bits = 9'h100;
    endcase
  endfunction

  // address decode for reads and writes
  function automatic logic is_reg(input logic [11:0] a, input logic [9:0] idx);
    is_reg = (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // ------------------------------------------------------------------
  // apb slave and registers
  // ------------------------------------------------------------------
  // one wait state; read data fetched in the first access cycle
  always_comb begin
    rd_en = psel & penable & ~pready_ff;
    wr_en = psel & penable & pready_ff & pwrite;
    hit   = 1'b1;
    rd_word = 32'h0000_0000;  // reserved bits read zero
    if (is_reg(paddr, `RFTX_IDX_LAST_BYTE)) begin
      rd_word[7:0] = lastb_ff;
    end else if (is_reg(paddr, `RFTX_IDX_BURST_LEN)) begin
      rd_word[7:0] = burst_ff;
    end else if (is_reg(paddr, `RFTX_IDX_WAIT_CTRL)) begin
      rd_word[7:0] = wctl_ff;
    end else if (is_reg(paddr, `RFTX_IDX_WAIT_LOW)) begin
      rd_word[7:0] = wlo_ff;
    end else if (is_reg(paddr, `RFTX_IDX_FRAME_CTRL)) begin
      rd_word[7:0] = frame_ff;
    end else if (is_reg(paddr, `RFTX_IDX_TX_CONTROL)) begin
      rd_word[7:0] = ctl_ff;
    end else if (is_reg(paddr, `RFTX_IDX_TX_STATUS)) begin
      rd_word[`RFTX_BUSY_BIT]   = (st_ff != rftx_pkg::RFTX_IDLE) | go_ff;
      rd_word[`RFTX_GAPRUN_BIT] = gap.busy;
      rd_word[`RFTX_PARERR_BIT] = parerr_ff;
    end else begin
      hit = 1'b0;
    end
    nxt_pready  = rd_en;
    nxt_pslverr = rd_en & ~hit;
    nxt_prdata  = rd_en ? rd_word : 32'h0000_0000;
    nxt_lastb = lastb_ff;
    nxt_burst = burst_ff;
    nxt_wctl  = wctl_ff;
    nxt_wlo   = wlo_ff;
    nxt_frame = frame_ff;
    nxt_ctl   = ctl_ff;
    nxt_go    = go_ff & (st_ff == rftx_pkg::RFTX_IDLE);
    // parity error set wins over the write-one clear
    nxt_parerr = parerr_ff;
    if (wr_en && is_reg(paddr, `RFTX_IDX_TX_STATUS) && pwdata[`RFTX_PARERR_BIT]) begin
      nxt_parerr = 1'b0;
    end
    if (rxe_ff) begin
      nxt_parerr = 1'b1;
    end
    if (wr_en) begin
      if (is_reg(paddr, `RFTX_IDX_LAST_BYTE)) begin
        nxt_lastb = {3'b000, pwdata[4:0]};
      end else if (is_reg(paddr, `RFTX_IDX_BURST_LEN)) begin
        nxt_burst = {1'b0, pwdata[6:4], 4'h0};
      end else if (is_reg(paddr, `RFTX_IDX_WAIT_CTRL)) begin
        nxt_wctl = pwdata[7:0];
      end else if (is_reg(paddr, `RFTX_IDX_WAIT_LOW)) begin
        nxt_wlo = pwdata[7:0];
      end else if (is_reg(paddr, `RFTX_IDX_FRAME_CTRL)) begin
        nxt_frame = {pwdata[7:6], 2'b00, pwdata[3:0]};
      end else if (is_reg(paddr, `RFTX_IDX_TX_CONTROL)) begin
        nxt_ctl = {5'b00000, pwdata[2:1], 1'b0};  // go reads zero
        nxt_go  = go_ff | pwdata[`RFTX_GO_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lastb_ff   <= `RFTX_RST_ZERO;
      burst_ff   <= `RFTX_RST_ZERO;
      wctl_ff    <= `RFTX_RST_WAIT_CTRL;
      wlo_ff     <= `RFTX_RST_ZERO;
      frame_ff   <= `RFTX_RST_ZERO;
      ctl_ff     <= `RFTX_RST_ZERO;
      go_ff      <= 1'b0;
      parerr_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      lastb_ff   <= nxt_lastb;
      burst_ff   <= nxt_burst;
      wctl_ff    <= nxt_wctl;
      wlo_ff     <= nxt_wlo;
      frame_ff   <= nxt_frame;
      ctl_ff     <= nxt_ctl;
      go_ff      <= nxt_go;
      parerr_ff  <= nxt_parerr;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ------------------------------------------------------------------
  // gap timer control
  // ------------------------------------------------------------------
  // the timer is armed by whichever frame end the start select names
  assign gap.arm      = wctl_ff[`RFTX_GAPSTART_BIT] ? rx_frame_end : tx_end;
  assign gap.count    = {wctl_ff[5:3], wlo_ff};
  assign gap.unit_sel = wctl_ff[`RFTX_GAPUNIT_BIT];

  // ------------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------------
  // successor of each optional section
  always_comb begin
    after_esym  = (wctl_ff[2:0] != 3'h0) ? rftx_pkg::RFTX_GUARD : rftx_pkg::RFTX_IDLE;
    after_data  = (frame_ff[3:2] != 2'b00) ? rftx_pkg::RFTX_ESYM : after_esym;
    after_burst = (lastb_ff[`RFTX_SEND_BIT] && tx_byte_valid) ? rftx_pkg::RFTX_DATA
                                                               : after_data;
    after_ssym  = ctl_ff[`RFTX_BURSTEN_BIT] ? rftx_pkg::RFTX_BURST : after_burst;
  end

  always_comb begin
    tick     = (etu_ff == ETU_LAST);
    nxt_st   = st_ff;
    nxt_etu  = (st_ff == rftx_pkg::RFTX_IDLE || st_ff == rftx_pkg::RFTX_GAP ||
                st_ff == rftx_pkg::RFTX_ALIGN || tick) ? '0 : etu_ff + 1'b1;
    nxt_grid = (grid_ff == ETU_LAST) ? '0 : grid_ff + 1'b1;
    nxt_cnt  = cnt_ff;
    nxt_sh   = sh_ff;
    nxt_last = last_ff;
    nxt_par  = par_ff;
    nxt_rdy  = 1'b0;
    tx_end   = 1'b0;
    case (st_ff)
      rftx_pkg::RFTX_IDLE: begin
        if (go_ff) begin
          nxt_st = rftx_pkg::RFTX_GAP;
        end
      end
      rftx_pkg::RFTX_GAP: begin
        if (!gap.busy) begin
          nxt_st = rftx_pkg::RFTX_ALIGN;
        end
      end
      rftx_pkg::RFTX_ALIGN: begin
        // grid phase restarts at each start so starts stay ETU multiples
        if (!lastb_ff[`RFTX_GRID_BIT] || grid_ff == '0) begin
          nxt_grid = EW'(1);
          nxt_st = (frame_ff[1:0] != 2'b00) ? rftx_pkg::RFTX_SSYM : after_ssym;
        end
      end
      rftx_pkg::RFTX_SSYM: begin
        if (tick) begin
          nxt_st = after_ssym;
        end
      end
      rftx_pkg::RFTX_BURST: begin
        if (tick) begin
          nxt_cnt = cnt_ff - 9'h001;
          if (cnt_ff == 9'h001) begin
            nxt_st = after_burst;
          end
        end
      end
      rftx_pkg::RFTX_DATA: begin
        if (tick) begin
          nxt_sh  = {1'b0, sh_ff[7:1]};
          nxt_par = par_ff ^ sh_ff[0];
          nxt_cnt = cnt_ff - 9'h001;
          if (cnt_ff == 9'h001) begin
            if (frame_ff[`RFTX_TXPAR_BIT]) begin
              nxt_st = rftx_pkg::RFTX_PAR;
            end else if (last_ff || !tx_byte_valid) begin
              nxt_st = after_data;
            end else begin
              nxt_st = rftx_pkg::RFTX_DATA;
            end
          end
        end
      end
      rftx_pkg::RFTX_PAR: begin
        if (tick) begin
          nxt_st = (last_ff || !tx_byte_valid) ? after_data : rftx_pkg::RFTX_DATA;
        end
      end
      rftx_pkg::RFTX_ESYM: begin
        if (tick) begin
          nxt_st = after_esym;
        end
      end
      rftx_pkg::RFTX_GUARD: begin
        if (tick) begin
          nxt_cnt = cnt_ff - 9'h001;
          if (cnt_ff == 9'h001) begin
            nxt_st = rftx_pkg::RFTX_IDLE;
          end
        end
      end
      default: nxt_st = rftx_pkg::RFTX_IDLE;
    endcase
    // loads done on entry to a counted section
    if (nxt_st == rftx_pkg::RFTX_BURST && st_ff != rftx_pkg::RFTX_BURST) begin
      nxt_cnt = burst_bits(burst_ff[6:4]);
    end
    if (nxt_st == rftx_pkg::RFTX_GUARD && st_ff != rftx_pkg::RFTX_GUARD) begin
      nxt_cnt = {6'h00, wctl_ff[2:0]};  // one stop bit plus code-1 guards
    end
    if (nxt_st == rftx_pkg::RFTX_DATA && (st_ff != rftx_pkg::RFTX_DATA || nxt_cnt == 9'h000)) begin
      nxt_sh   = tx_byte;
      nxt_last = tx_byte_last;
      nxt_par  = 1'b1;  // odd parity
      nxt_rdy  = 1'b1;
      // only the low bits of the final byte go out, lsb first
      nxt_cnt  = (tx_byte_last && lastb_ff[2:0] != 3'h0) ? {6'h00, lastb_ff[2:0]}
                                                          : 9'h008;
    end
    if (st_ff != rftx_pkg::RFTX_IDLE && st_ff != rftx_pkg::RFTX_GAP &&
        st_ff != rftx_pkg::RFTX_ALIGN && nxt_st == rftx_pkg::RFTX_IDLE) begin
      tx_end = 1'b1;
    end
  end

  // per-ETU output strobe with the kind and level of the element
  always_comb begin
    nxt_strobe = (etu_ff == '0);
    nxt_kind   = rftx_pkg::RFTX_K_STOP;
    nxt_bit    = 1'b1;
    nxt_sym    = 2'b00;
    case (st_ff)
      rftx_pkg::RFTX_SSYM: begin
        nxt_kind = rftx_pkg::RFTX_K_SYMBOL;
        nxt_sym  = frame_ff[1:0] - 2'b01;
      end
      rftx_pkg::RFTX_ESYM: begin
        nxt_kind = rftx_pkg::RFTX_K_SYMBOL;
        nxt_sym  = frame_ff[3:2] - 2'b01;
      end
      rftx_pkg::RFTX_BURST: begin
        nxt_kind = rftx_pkg::RFTX_K_BURST;
        nxt_bit  = ctl_ff[`RFTX_BURSTLVL_BIT];
      end
      rftx_pkg::RFTX_DATA: begin
        nxt_kind = rftx_pkg::RFTX_K_DATA;
        nxt_bit  = sh_ff[0];
      end
      rftx_pkg::RFTX_PAR: begin
        nxt_kind = rftx_pkg::RFTX_K_PARITY;
        nxt_bit  = par_ff;
      end
      rftx_pkg::RFTX_GUARD: nxt_kind = rftx_pkg::RFTX_K_STOP;
      default: nxt_strobe = 1'b0;
    endcase
  end

  // rx bytes: parity checked, parity bit dropped, byte passed on
  always_comb begin
    nxt_rxv = rx_in_valid;
    nxt_rxb = rx_in_data[7:0];
    nxt_rxe = rx_in_valid & frame_ff[`RFTX_RXPAR_BIT] & ~(^rx_in_data);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff     <= rftx_pkg::RFTX_IDLE;
      etu_ff    <= '0;
      grid_ff   <= '0;
      cnt_ff    <= 9'h000;
      sh_ff     <= 8'h00;
      last_ff   <= 1'b0;
      par_ff    <= 1'b1;
      rdy_ff    <= 1'b0;
      strobe_ff <= 1'b0;
      kind_ff   <= 3'h0;
      bit_ff    <= 1'b1;
      sym_ff    <= 2'b00;
      rxb_ff    <= 8'h00;
      rxv_ff    <= 1'b0;
      rxe_ff    <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      etu_ff    <= nxt_etu;
      grid_ff   <= nxt_grid;
      cnt_ff    <= nxt_cnt;
      sh_ff     <= nxt_sh;
      last_ff   <= nxt_last;
      par_ff    <= nxt_par;
      rdy_ff    <= nxt_rdy;
      strobe_ff <= nxt_strobe;
      kind_ff   <= nxt_kind;
      bit_ff    <= nxt_bit;
      sym_ff    <= nxt_sym;
      rxb_ff    <= nxt_rxb;
      rxv_ff    <= nxt_rxv;
      rxe_ff    <= nxt_rxe;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign tx_byte_ready = rdy_ff;
  assign tx_strobe     = strobe_ff;
  assign tx_kind       = kind_ff;
  assign tx_bit        = bit_ff;
  assign tx_symbol     = sym_ff;
  assign rx_byte       = rxb_ff;
  assign rx_byte_valid = rxv_ff;
  assign rx_parity_err = rxe_ff;
endmodule // rftx_framer
`default_nettype wire

// File: test/rftx_framer_asserts.sv
// port checker for the tx framer
`default_nettype none
module rftx_framer_asserts #(
  parameter int ETU_CYCLES = 64
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        tx_byte_valid,
  input wire logic        tx_byte_ready,
  input wire logic        tx_strobe,
  input wire logic [2:0]  tx_kind,
  input wire logic        tx_bit,
  input wire logic [1:0]  tx_symbol,
  input wire logic [8:0]  rx_in_data,
  input wire logic        rx_in_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_byte_valid,
  input wire logic        rx_parity_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        acc_ff, nxt_acc;
  logic [15:0] since_ff, nxt_since;
  // data-bit xor; cycles since last strobe
  always_comb begin
    nxt_acc = acc_ff;
    if (tx_strobe) nxt_acc = (tx_kind == 3'h0) ? (acc_ff ^ tx_bit) : 1'b0;
    nxt_since = (since_ff == 16'hffff) ? since_ff : since_ff + 16'h0001;
    if (tx_strobe) nxt_since = 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff   <= 1'b0;
      since_ff <= 16'hffff;
    end else begin
      acc_ff   <= nxt_acc;
      since_ff <= nxt_since;
    end
  end
  // ----
  // apb access steps
  // ----
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  chk_apb_one_wait: assert property (s_setup |=> s_wait ##1 pready)
    else $error("apb wait state wrong");
  chk_refused_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access gave data");
  chk_parity_odd: assert property (tx_strobe && tx_kind == 3'h1 |-> tx_bit == !acc_ff)
    else $error("parity bit not odd");
  chk_etu_spacing: assert property (tx_strobe |-> since_ff >= ETU_CYCLES)
    else $error("elements under one etu");
  chk_stop_level: assert property (tx_strobe && tx_kind == 3'h4 |-> tx_bit)
    else $error("stop level not one");
  chk_symbol_range: assert property (tx_strobe && tx_kind == 3'h2 |-> tx_symbol != 2'h3)
    else $error("symbol out of range");
  chk_byte_take: assert property (tx_byte_ready |-> $past(tx_byte_valid))
    else $error("byte taken without valid");
  chk_rx_pass: assert property (rx_in_valid |=> rx_byte_valid && rx_byte == $past(rx_in_data[7:0]))
    else $error("rx byte not passed");
  chk_rx_parity: assert property (rx_parity_err |-> $past(rx_in_valid) && !$past(^rx_in_data))
    else $error("parity error unfounded");
endmodule // rftx_framer_asserts
bind rftx_framer rftx_framer_asserts #(.ETU_CYCLES(ETU_CYCLES)) rftx_framer_asserts_i (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .tx_byte_valid,
  .tx_byte_ready, .tx_strobe, .tx_kind, .tx_bit, .tx_symbol, .rx_in_data,
  .rx_in_valid, .rx_byte, .rx_byte_valid, .rx_parity_err
);
`default_nettype wire

// File: test/rftx_tag_model.sv
// tag in the field: answers each heard frame with one byte
`default_nettype none
module rftx_tag_model #(
  parameter int ETU_CYCLES = 8
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_strobe,
  input  wire logic [7:0] reply_delay,
  input  wire logic       bad_parity,
  output logic [8:0]      rx_in_data,
  output logic            rx_in_valid,
  output logic            rx_frame_end
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REPLY = 8'h5a;
  logic        heard_ff;
  logic [15:0] quiet_ff;
  // data toggles when not valid so a stale value never looks good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heard_ff     <= 1'b0;
      quiet_ff     <= 16'h0000;
      rx_in_data   <= 9'h000;
      rx_in_valid  <= 1'b0;
      rx_frame_end <= 1'b0;
    end else begin
      rx_in_valid  <= 1'b0;
      rx_frame_end <= rx_in_valid;
      rx_in_data   <= ~rx_in_data;
      quiet_ff     <= tx_strobe ? 16'h0000 : quiet_ff + 16'h0001;
      if (tx_strobe) begin
        heard_ff <= 1'b1;
      end else if (heard_ff && quiet_ff == 16'(2 * ETU_CYCLES) + {8'h00, reply_delay}) begin
        heard_ff    <= 1'b0;
        rx_in_valid <= 1'b1;
        rx_in_data  <= {~^REPLY ^ bad_parity, REPLY};
      end
    end
  end
endmodule // rftx_tag_model
`default_nettype wire

// File: test/rftx_framer_tb_top.sv
// register and framing testbench for the tx framer
`default_nettype none
`include "rftx_consts.svh"
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) begin \
      bad_count++; \
      $display("ERROR %0t mismatch got %0h exp %0h", $time, (a), (b)); \
    end \
  end
module rftx_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ETU = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  tx_byte, rx_byte, reply_delay;
  logic        tx_byte_valid, tx_byte_last, tx_byte_ready, tx_strobe, tx_bit;
  logic [2:0]  tx_kind;
  logic [1:0]  tx_symbol;
  logic [8:0]  rx_in_data;
  logic        rx_frame_end, rx_in_valid, rx_byte_valid, rx_parity_err, bad_parity;
  logic [5:0]  sq[$];
  int          tq[$];
  int          cyc, rxe, bad_count, checks;
  logic [9:0]  ridx[5] = '{`RFTX_IDX_LAST_BYTE, `RFTX_IDX_BURST_LEN, `RFTX_IDX_WAIT_CTRL,
                         `RFTX_IDX_WAIT_LOW, `RFTX_IDX_FRAME_CTRL};
  logic [7:0]  rmsk[5] = '{8'h1f, 8'h70, 8'hff, 8'hff, 8'hcf};
  int          blen[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
  logic [7:0]  gctl[3] = '{8'h40, 8'h00, 8'h48};
  logic [7:0]  glo[3] = '{8'h03, 8'h02, 8'h00};
  int          gmin[3] = '{3 * ETU / 2, 2 * `RFTX_CARRIER_UNIT_CYC, 256 * ETU / 2};
  rftx_framer #(.ETU_CYCLES(ETU)) rftx_framer_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_byte, .tx_byte_valid, .tx_byte_last, .tx_byte_ready, .tx_strobe,
    .tx_kind, .tx_bit, .tx_symbol, .rx_frame_end, .rx_in_data, .rx_in_valid,
    .rx_byte, .rx_byte_valid, .rx_parity_err
  );
  rftx_tag_model #(.ETU_CYCLES(ETU)) rftx_tag_model_i (
    .pclk, .presetn, .tx_strobe, .reply_delay, .bad_parity, .rx_in_data,
    .rx_in_valid, .rx_frame_end
  );
  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // element log: symbols keep their number, others their bit level
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tx_strobe === 1'b1) begin
      sq.push_back(tx_kind == 3'h2 ? {tx_kind, 1'b0, tx_symbol} : {tx_kind, tx_bit, 2'h0});
      tq.push_back(cyc);
    end
    if (rx_frame_end === 1'b1) rxe <= cyc;
    if (tx_byte_ready === 1'b1) tx_byte_valid <= 1'b0;
  end
  // ----
  // bus and check tasks
  // ----
  task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ix, d, r, e);
  endtask
  task automatic rdx(input logic [9:0] ix, input logic [7:0] x, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ix, 8'h00, r, e);
    `CHK(r & m, {24'h00_0000, x} & m);
  endtask
  // waits for n elements, then a few etus more to catch extras
  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (sq.size() < n && k < 6000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 6000) begin
      bad_count++;
      final_report();
    end
    repeat (4 * ETU) @(posedge pclk);
  endtask
  task automatic chk_q(input logic [5:0] e[$]);
    `CHK(sq.size(), e.size());
    foreach (e[i]) if (i < sq.size()) `CHK(sq[i], e[i]);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {tx_byte, tx_byte_valid, tx_byte_last} = {8'hb2, 2'b01};
    {reply_delay, bad_parity, cyc, rxe, bad_count, checks} = '0;
    reply_delay = 8'h20;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdx(`RFTX_IDX_WAIT_CTRL, 8'hc0, 32'hffff_ffff);
    foreach (ridx[i]) begin
      wr(ridx[i], 8'hff);
      rdx(ridx[i], rmsk[i], 32'hffff_ffff);
    end
    apb(1'b0, 10'h3ff, 8'h00, r, e);
    `CHK({e, r}, {1'b1, 32'h0000_0000});
    // partial byte, parity, both symbols, two stops
    wr(`RFTX_IDX_LAST_BYTE, 8'h0b);
    wr(`RFTX_IDX_FRAME_CTRL, 8'h8d);
    wr(`RFTX_IDX_WAIT_CTRL, 8'h42);
    wr(`RFTX_IDX_WAIT_LOW, 8'h00);
    tx_byte_valid <= 1'b1;
    wr(`RFTX_IDX_TX_CONTROL, 8'h01);
    wait_q(8);
    chk_q({6'h10, 6'h00, 6'h04, 6'h00, 6'h08, 6'h12, 6'h24, 6'h24});
    // burst only, every length code, level alternating
    wr(`RFTX_IDX_LAST_BYTE, 8'h00);
    wr(`RFTX_IDX_FRAME_CTRL, 8'h00);
    wr(`RFTX_IDX_WAIT_CTRL, 8'h40);
    for (int c = 0; c < 8; c++) begin
      sq = {};
      wr(`RFTX_IDX_BURST_LEN, {1'b0, 3'(c), 4'h0});
      wr(`RFTX_IDX_TX_CONTROL, {5'h00, 1'(c), 2'b11});
      wait_q(blen[c]);
      n = 0;
      foreach (sq[i]) n += int'(sq[i] === {3'h3, 1'(c), 2'h0});
      `CHK(n, blen[c]);
      `CHK(sq.size(), blen[c]);
    end
    // second start held off by the gap
    wr(`RFTX_IDX_FRAME_CTRL, 8'h01);
    for (int g = 0; g < 3; g++) begin
      sq = {};
      tq = {};
      wr(`RFTX_IDX_WAIT_CTRL, gctl[g]);
      wr(`RFTX_IDX_WAIT_LOW, glo[g]);
      wr(`RFTX_IDX_TX_CONTROL, 8'h01);
      wait_q(1);
      wr(`RFTX_IDX_TX_CONTROL, 8'h01);
      wait_q(2);
      `CHK(tq[1] - tq[0] >= gmin[g], 1'b1);
    end
    // gap from the reply, which has bad parity
    sq = {};
    tq = {};
    bad_parity <= 1'b1;
    wr(`RFTX_IDX_FRAME_CTRL, 8'h41);
    wr(`RFTX_IDX_WAIT_CTRL, 8'hc0);
    wr(`RFTX_IDX_WAIT_LOW, 8'h28);
    wr(`RFTX_IDX_TX_CONTROL, 8'h01);
    wait_q(1);
    n = 0;
    while (rxe <= tq[0] && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) bad_count++;
    bad_parity <= 1'b0;
    wr(`RFTX_IDX_TX_CONTROL, 8'h01);
    wait_q(2);
    `CHK(tq[1] >= rxe + 40 * ETU / 2, 1'b1);
    rdx(`RFTX_IDX_TX_STATUS, 8'h04, 32'h0000_0004);
    wr(`RFTX_IDX_TX_STATUS, 8'h04);
    rdx(`RFTX_IDX_TX_STATUS, 8'h00, 32'h0000_0004);
    final_report();
  end
endmodule // rftx_framer_tb_top
`default_nettype wire
